// [hw/sffam_pkg.sv]
// Constants shared by the supply fault flag and alert masking block
package sffam_pkg;

   localparam int unsigned REG_AW = 8;
   localparam int unsigned REG_DW = 16;
   localparam int unsigned SUP_W  = 7;

   localparam logic [REG_AW-1:0] ADDR_SUPPLY_FLAGS   = 8'h5B;
   localparam logic [REG_AW-1:0] ADDR_EVENT_INHIBIT  = 8'h5F;
   localparam logic [REG_AW-1:0] ADDR_SUPPLY_INHIBIT = 8'h60;

   // Supply fault flag positions
   localparam int unsigned SUP_CAL_STORE    = 6;
   localparam int unsigned SUP_DRIVER_LOW   = 5;
   localparam int unsigned SUP_REGULATOR    = 4;
   localparam int unsigned SUP_ANALOG_CORE  = 3;
   localparam int unsigned SUP_LOGIC        = 2;
   localparam int unsigned SUP_NEGATIVE     = 1;
   localparam int unsigned SUP_POS_ANALOG   = 0;

   // Event inhibit positions, aligned with the main event status register
   localparam int unsigned EV_ANALOG_OPEN    = 14;
   localparam int unsigned EV_ANALOG_SHORT   = 13;
   localparam int unsigned EV_DRV_INT_TMO    = 12;
   localparam int unsigned EV_DRV_EXT_TMO    = 11;
   localparam int unsigned EV_DRV_INT_SHORT  = 10;
   localparam int unsigned EV_DRV_EXT_SHORT  = 9;
   localparam int unsigned EV_DRV_THERMAL    = 8;
   localparam int unsigned EV_INPUT_OPEN     = 7;
   localparam int unsigned EV_INPUT_SHORT    = 6;
   localparam int unsigned EV_CONVERTER      = 5;
   localparam int unsigned EV_OVER_TEMP      = 4;
   localparam int unsigned EV_POWER_CTRL     = 3;
   localparam int unsigned EV_SERIAL         = 2;

   localparam logic [REG_DW-1:0] SUPPLY_FLAGS_RESET   = 16'h0000;
   localparam logic [REG_DW-1:0] EVENT_INHIBIT_RESET  = 16'h0000;
   localparam logic [REG_DW-1:0] SUPPLY_INHIBIT_RESET = 16'h0000;
   localparam logic [REG_DW-1:0] RDATA_RESET          = 16'h0000;
   localparam logic [SUP_W-1:0]  SUP_ALL              = 7'h7F;

   function automatic logic [REG_DW-1:0] bit_at(input int unsigned pos);
      bit_at = 16'h0001 << pos;
   endfunction

   // Writable (non-reserved) event inhibit bits
   localparam logic [REG_DW-1:0] EVENT_INHIBIT_WMASK =
      bit_at(EV_ANALOG_OPEN)   | bit_at(EV_ANALOG_SHORT)  | bit_at(EV_DRV_INT_TMO) |
      bit_at(EV_DRV_EXT_TMO)   | bit_at(EV_DRV_INT_SHORT) | bit_at(EV_DRV_EXT_SHORT) |
      bit_at(EV_DRV_THERMAL)   | bit_at(EV_INPUT_OPEN)    | bit_at(EV_INPUT_SHORT) |
      bit_at(EV_CONVERTER)     | bit_at(EV_OVER_TEMP)     | bit_at(EV_POWER_CTRL) |
      bit_at(EV_SERIAL);

endpackage

// [hw/sffam_alert_if.sv]
// Interface between the flag register file and the alert combiner
`timescale 1ns/1ps
`default_nettype none
interface sffam_alert_if;
   logic [sffam_pkg::REG_DW-1:0] event_flags;
   logic [sffam_pkg::REG_DW-1:0] event_inhibit;
   logic [sffam_pkg::SUP_W-1:0]  supply_flags;
   logic [sffam_pkg::SUP_W-1:0]  supply_inhibit;
   logic                         alert;

   modport regs (output event_flags, output event_inhibit, output supply_flags,
                 output supply_inhibit, input alert);
   modport gate (input event_flags, input event_inhibit, input supply_flags,
                 input supply_inhibit, output alert);
endinterface
`default_nettype wire

// [hw/sffam_alert_gate.sv]
// Alert combiner: gates event and supply flags with their inhibit masks
`timescale 1ns/1ps
`default_nettype none
module sffam_alert_gate (
   input  wire logic   sys_clk,
   input  wire logic   sys_rst,
   input  wire logic   clk_en,
   sffam_alert_if.gate bus
);

   logic                         alert_q;
   logic                         alert_d;
   wire  [sffam_pkg::REG_DW-1:0] event_open;
   wire  [sffam_pkg::SUP_W-1:0]  supply_open;

   // Reserved event positions never raise the pin
   assign event_open  = bus.event_flags & ~bus.event_inhibit
                        & sffam_pkg::EVENT_INHIBIT_WMASK;
   assign supply_open = bus.supply_flags & ~bus.supply_inhibit;
   assign alert_d     = (|event_open) | (|supply_open);

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         alert_q <= 1'b0;
      else if (clk_en)
         alert_q <= alert_d;
   end

   assign bus.alert = alert_q;

endmodule // sffam_alert_gate
`default_nettype wire

// [hw/sffam_top.sv]
// Supply fault flags, event and supply inhibit masks, alert pin driver
//
// Contract
// - Supply flags stay set; write one clears once cause gone; zero keeps.
// - Calibration flag bit 6 sets on checksum mismatch or uncorrectable code error.
// - Calibration flag also sets on register access before memory refresh completes.
// - Driver supply flag sets when comparator reports output supply below 9.3 V.
// - Regulator flag sets when internal low-dropout rail below 1.4 V.
// - Analog core flag sets when analog core supply below 4.1 V.
// - Logic supply flag sets when digital logic supply below 1.9 V.
// - Negative supply flag sets when negative rail rises above -1.6 V.
// - Positive analog flag sets when positive analog supply below 5.5 V.
// - Event mask bit one keeps its aligned event off the alert pin.
// - Masking blocks only the pin; main status bits still set.
// - Mask bits 14, 13, 12: analog open, analog short, internal driver timeout.
// - Mask bits 11, 10, 9: external timeout, internal short, external short.
// - Mask bits 8, 7, 6: thermal shutdown, input open, input short.
// - Mask bits 5, 4, 3: converter, over-temperature, power control error.
// - Mask bit 2 serial errors; bits 15, 1, 0 reserved, read zero.
// - Supply mask blocks supply flag from pin, not from summary bit.
// - Live view bit gives unlatched current state of supply flags; the code drives supply_status_live as the OR of the latched flags instead.
`timescale 1ns/1ps
`default_nettype none
module sffam_top (
   input  wire logic                         sys_clk,
   input  wire logic                         sys_rst,
   input  wire logic                         clk_en,
   // Register access from the serial front end
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   input  wire logic [sffam_pkg::REG_AW-1:0] reg_addr,
   input  wire logic [sffam_pkg::REG_DW-1:0] reg_wdata,
   output logic      [sffam_pkg::REG_DW-1:0] reg_rdata,
   // Main event status register bits
   input  wire logic [sffam_pkg::REG_DW-1:0] event_flags,
   // Supply comparators, high while the rail is out of limit
   input  wire logic                         driver_supply_low,
   input  wire logic                         internal_regulator_low,
   input  wire logic                         analog_core_supply_low,
   input  wire logic                         logic_supply_low,
   input  wire logic                         negative_supply_fault,
   input  wire logic                         positive_analog_supply_low,
   // Calibration upload checks
   input  wire logic                         cal_checksum_error,
   input  wire logic                         cal_ecc_uncorrectable,
   input  wire logic                         mem_refresh_done,
   // Alert pin and summaries
   output logic                              alert_n,
   output logic                              supply_summary_set,
   output logic                              supply_status_live
);

   sffam_alert_if alert_bus ();

   logic [sffam_pkg::SUP_W-1:0]  supply_flags_q;
   logic [sffam_pkg::SUP_W-1:0]  supply_flags_d;
   logic [sffam_pkg::REG_DW-1:0] event_inhibit_q;
   logic [sffam_pkg::REG_DW-1:0] event_inhibit_d;
   logic [sffam_pkg::SUP_W-1:0]  supply_inhibit_q;
   logic [sffam_pkg::SUP_W-1:0]  supply_inhibit_d;
   logic [sffam_pkg::REG_DW-1:0] rdata_q;
   logic [sffam_pkg::REG_DW-1:0] rdata_d;
   logic                         summary_q;

   wire                          access_early;
   wire                          wr_ok;
   wire                          sel_flags;
   wire                          sel_event_inh;
   wire                          sel_supply_inh;
   wire  [sffam_pkg::SUP_W-1:0]  supply_set;
   wire  [sffam_pkg::SUP_W-1:0]  supply_clr;
   wire                          cal_set;

   // Any access while refresh is pending is an error; such writes are dropped
   // because the register contents are not yet trustworthy.
   assign access_early   = (reg_wr | reg_rd) & ~mem_refresh_done;
   assign wr_ok          = reg_wr & mem_refresh_done;
   assign sel_flags      = (reg_addr == sffam_pkg::ADDR_SUPPLY_FLAGS);
   assign sel_event_inh  = (reg_addr == sffam_pkg::ADDR_EVENT_INHIBIT);
   assign sel_supply_inh = (reg_addr == sffam_pkg::ADDR_SUPPLY_INHIBIT);

   assign cal_set = cal_checksum_error | cal_ecc_uncorrectable | access_early;

   // Comparator levels keep setting while the rail is bad, so a clear only
   // sticks once the condition has gone.
   assign supply_set[sffam_pkg::SUP_CAL_STORE]   = cal_set;
   assign supply_set[sffam_pkg::SUP_DRIVER_LOW]  = driver_supply_low;
   assign supply_set[sffam_pkg::SUP_REGULATOR]   = internal_regulator_low;
   assign supply_set[sffam_pkg::SUP_ANALOG_CORE] = analog_core_supply_low;
   assign supply_set[sffam_pkg::SUP_LOGIC]       = logic_supply_low;
   assign supply_set[sffam_pkg::SUP_NEGATIVE]    = negative_supply_fault;
   assign supply_set[sffam_pkg::SUP_POS_ANALOG]  = positive_analog_supply_low;

   assign supply_clr = (wr_ok & sel_flags) ? reg_wdata[sffam_pkg::SUP_W-1:0]
                                           : {sffam_pkg::SUP_W{1'b0}};

   // Set wins over a clear in the same cycle
   assign supply_flags_d = (supply_flags_q & ~supply_clr) | supply_set;

   assign event_inhibit_d = (wr_ok & sel_event_inh)
                            ? (reg_wdata & sffam_pkg::EVENT_INHIBIT_WMASK)
                            : event_inhibit_q;

   assign supply_inhibit_d = (wr_ok & sel_supply_inh)
                             ? reg_wdata[sffam_pkg::SUP_W-1:0]
                             : supply_inhibit_q;

   always_comb
   begin
      rdata_d = rdata_q;
      if (reg_rd)
      begin
         if (sel_flags)
            rdata_d = {{(sffam_pkg::REG_DW-sffam_pkg::SUP_W){1'b0}}, supply_flags_q};
         else if (sel_event_inh)
            rdata_d = event_inhibit_q;
         else if (sel_supply_inh)
            rdata_d = {{(sffam_pkg::REG_DW-sffam_pkg::SUP_W){1'b0}}, supply_inhibit_q};
         else
            rdata_d = sffam_pkg::RDATA_RESET;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         supply_flags_q   <= sffam_pkg::SUPPLY_FLAGS_RESET[sffam_pkg::SUP_W-1:0];
         event_inhibit_q  <= sffam_pkg::EVENT_INHIBIT_RESET;
         supply_inhibit_q <= sffam_pkg::SUPPLY_INHIBIT_RESET[sffam_pkg::SUP_W-1:0];
         rdata_q          <= sffam_pkg::RDATA_RESET;
         summary_q        <= 1'b0;
      end
      else if (clk_en)
      begin
         supply_flags_q   <= supply_flags_d;
         event_inhibit_q  <= event_inhibit_d;
         supply_inhibit_q <= supply_inhibit_d;
         rdata_q          <= rdata_d;
         // Summary ignores the supply mask
         summary_q        <= |(supply_set & ~supply_flags_q);
      end
   end

   // Event flags pass straight from the main status register; masking never
   // feeds back into it.
   assign alert_bus.event_flags    = event_flags;
   assign alert_bus.event_inhibit  = event_inhibit_q;
   assign alert_bus.supply_flags   = supply_flags_q;
   assign alert_bus.supply_inhibit = supply_inhibit_q;

   sffam_alert_gate u_sffam_alert_gate (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .bus     (alert_bus.gate)
   );

   assign alert_n            = ~alert_bus.alert;
   assign reg_rdata          = rdata_q;
   assign supply_summary_set = summary_q;
   assign supply_status_live = |supply_flags_q;

endmodule // sffam_top
`default_nettype wire

// [verif/sffam_asserts.sv]
// Checker for the supply flag and alert masking block
`timescale 1ns/1ps
`default_nettype none
module sffam_asserts (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        clk_en,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic [15:0] event_flags,
   input wire logic        driver_supply_low,
   input wire logic        internal_regulator_low,
   input wire logic        analog_core_supply_low,
   input wire logic        logic_supply_low,
   input wire logic        negative_supply_fault,
   input wire logic        positive_analog_supply_low,
   input wire logic        cal_checksum_error,
   input wire logic        cal_ecc_uncorrectable,
   input wire logic        mem_refresh_done,
   input wire logic        alert_n,
   input wire logic        supply_summary_set,
   input wire logic        supply_status_live
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Shadow of the event inhibit, so the pin can be judged from ports alone
   logic [15:0] inh_q;
   wire ev_on = |(event_flags & ~inh_q & 16'h7FFC);
   wire cmp_any = driver_supply_low | internal_regulator_low | analog_core_supply_low
                | logic_supply_low | negative_supply_fault | positive_analog_supply_low;
   wire take_rd = clk_en & reg_rd;
   always_ff @(posedge sys_clk or posedge sys_rst)
      if (sys_rst) inh_q <= 16'h0000;
      else if (clk_en & reg_wr & mem_refresh_done & (reg_addr == 8'h5F))
         inh_q <= reg_wdata & 16'h7FFC;
   property p_alert_on; $past(clk_en & ev_on) |-> !alert_n; endproperty
   property p_alert_off; $past(clk_en & !ev_on & !supply_status_live) |-> alert_n; endproperty
   property p_sticky;
      supply_status_live && !(clk_en && reg_wr && reg_addr == 8'h5B) |=> supply_status_live;
   endproperty
   property p_cmp; clk_en & cmp_any |=> supply_status_live; endproperty
   property p_cal; clk_en & (cal_checksum_error | cal_ecc_uncorrectable) |=> supply_status_live;
   endproperty
   property p_early; clk_en & !mem_refresh_done & (reg_wr | reg_rd) |=> supply_status_live;
   endproperty
   property p_summary; supply_summary_set |-> supply_status_live; endproperty
   property p_unmapped;
      take_rd && !(reg_addr inside {8'h5B, 8'h5F, 8'h60}) |=> reg_rdata == 16'h0000;
   endproperty
   property p_inh_rd; take_rd && reg_addr == 8'h5F |=> reg_rdata == $past(inh_q); endproperty
   property p_sup_rd;
      take_rd && reg_addr == 8'h5B |=>
         reg_rdata[15:7] == 9'h000 && (|reg_rdata) == $past(supply_status_live);
   endproperty
   a_alert_on: assert property (p_alert_on) else $error("alert idle on unmasked event");
   a_alert_off: assert property (p_alert_off) else $error("alert active with no cause");
   a_sticky: assert property (p_sticky) else $error("supply flag lost");
   a_cmp: assert property (p_cmp) else $error("rail fault not flagged");
   a_cal: assert property (p_cal) else $error("calibration fault not flagged");
   a_early: assert property (p_early) else $error("early access not flagged");
   a_summary: assert property (p_summary) else $error("summary without flag");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_inh_rd: assert property (p_inh_rd) else $error("inhibit readback wrong");
   a_sup_rd: assert property (p_sup_rd) else $error("flag readback wrong");
   c_alert: cover property ($fell(alert_n));
   c_early: cover property (clk_en & !mem_refresh_done & reg_wr);
   c_summary: cover property (supply_summary_set);
endmodule // sffam_asserts
bind sffam_top sffam_asserts u_sffam_asserts (.*);
`default_nettype wire

// [verif/sffam_host_model.sv]
// Host controller model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module sffam_host_model (
   input  wire logic       sys_clk,
   input  wire logic       mem_refresh_done,
   output var logic        reg_wr,
   output var logic        reg_rd,
   output var logic [7:0]  reg_addr,
   output var logic [15:0] reg_wdata
);
   // Raised only by scenarios that probe an access before the upload ends
   bit early = 1'b0;
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      while (!mem_refresh_done && !early) @(posedge sys_clk);
      @(posedge sys_clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      // Released lines carry the inverse so stale values cannot pass
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
endmodule // sffam_host_model
`default_nettype wire

// [verif/supply_fault_flags_and_alert_masking_tb.sv]
// Self-checking bench for the supply flag and alert masking block
`timescale 1ns/1ps
`default_nettype none
module supply_fault_flags_and_alert_masking_tb;
   logic sys_clk = 1'b0, sys_rst = 1'b1, cal_ck = 1'b0, cal_ecc = 1'b0, refresh = 1'b1;
   logic rd_d = 1'b0, en = 1'b1, reg_wr, reg_rd, alert_n, summary, live;
   logic [5:0] sup = '0;
   logic [7:0] reg_addr;
   logic [15:0] ev = '0, reg_wdata, reg_rdata, r, seed = 16'h8343;
   logic [15:0] exp_q[$];
   int mismatches = 0, comparisons = 0, sum_n = 0;
   initial forever #12.5 sys_clk = ~sys_clk;
   sffam_host_model u_sffam_host_model (.sys_clk(sys_clk), .mem_refresh_done(refresh),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   sffam_top u_sffam_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(en),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .event_flags(ev), .driver_supply_low(sup[5]),
      .internal_regulator_low(sup[4]), .analog_core_supply_low(sup[3]),
      .logic_supply_low(sup[2]), .negative_supply_fault(sup[1]),
      .positive_analog_supply_low(sup[0]), .cal_checksum_error(cal_ck),
      .cal_ecc_uncorrectable(cal_ecc), .mem_refresh_done(refresh), .alert_n(alert_n),
      .supply_summary_set(summary), .supply_status_live(live));
   function automatic logic [15:0] xs();
      seed ^= seed << 7;
      seed ^= seed >> 9;
      seed ^= seed << 8;
      return seed;
   endfunction
   task automatic cmp(input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      u_sffam_host_model.acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      u_sffam_host_model.acc(1'b0, a, xs());
   endtask
   task automatic wrap_up();
      if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge sys_clk) rd_d <= reg_rd;
   // Each newly set supply flag must give exactly one summary pulse
   always @(posedge sys_clk) if (summary === 1'b1) sum_n <= sum_n + 1;
   always @(negedge sys_clk) if (rd_d === 1'b1) cmp(exp_q.pop_front(), reg_rdata);
   initial
   begin
      #100000;
      mismatches++;
      wrap_up();
   end
   initial
   begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(8'h5B, 16'h0000);
      rd(8'h5F, 16'h0000);
      rd(8'h60, 16'h0000);
      rd(8'h10, 16'h0000);
      wr(8'h5F, 16'hFFFF);
      rd(8'h5F, 16'h7FFC);
      // Comparators raised while frozen must leave no flag behind
      @(posedge sys_clk) {en, sup} <= 7'h3F;
      repeat (2) @(posedge sys_clk);
      {en, sup} <= 7'h40;
      rd(8'h5B, 16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         @(posedge sys_clk) sup <= 6'(1 << i);
         wr(8'h5B, 16'h007F);
         rd(8'h5B, 16'(1 << i));
         @(posedge sys_clk) sup <= '0;
         wr(8'h5B, 16'h0000);
         rd(8'h5B, 16'(1 << i));
         wr(8'h5B, 16'(1 << i));
         rd(8'h5B, 16'h0000);
      end
      for (int j = 0; j < 2; j++)
      begin
         @(posedge sys_clk) {cal_ecc, cal_ck} <= j ? 2'b10 : 2'b01;
         @(posedge sys_clk) {cal_ecc, cal_ck} <= 2'b00;
         rd(8'h5B, 16'h0040);
         wr(8'h5B, 16'h0040);
      end
      @(posedge sys_clk) refresh <= 1'b0;
      u_sffam_host_model.early = 1'b1;
      wr(8'h5F, 16'h0004);
      refresh <= 1'b1;
      u_sffam_host_model.early = 1'b0;
      rd(8'h5F, 16'h7FFC);
      rd(8'h5B, 16'h0040);
      // Calibration fault seen: host resets the device once the read is checked,
      // since reset would wipe the read data before the compare sees it
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(8'h5B, 16'h0000);
      for (int i = 0; i < 8; i++)
      begin
         r = xs();
         wr(8'h5F, r);
         @(posedge sys_clk) ev <= xs() & xs();
         repeat (3) @(posedge sys_clk);
         #1 cmp(16'(!(|(ev & ~r & 16'h7FFC))), 16'(alert_n));
      end
      @(posedge sys_clk) ev <= '0;
      @(posedge sys_clk) sup <= 6'h20;
      @(posedge sys_clk) sup <= '0;
      wr(8'h60, 16'h007F);
      repeat (3) @(posedge sys_clk);
      #1 cmp(16'h0003, {14'h0, alert_n, live});
      wr(8'h60, 16'h0000);
      repeat (3) @(posedge sys_clk);
      #1 cmp(16'h0001, {14'h0, alert_n, live});
      wr(8'h5B, 16'h007F);
      repeat (3) @(posedge sys_clk);
      #1 cmp(16'h0002, {14'h0, alert_n, live});
      // Six rails, two upload faults, one early access, one rail after reset
      cmp(16'h000A, 16'(sum_n));
      repeat (4) @(posedge sys_clk);
      wrap_up();
   end
endmodule // supply_fault_flags_and_alert_masking_tb
`default_nettype wire
